//--- bench/pba_bus_masters.sv
// Model of the four processor bus masters facing the slave and arbiter
module pba_bus_masters (
    input  wire logic        aclk,
    input  wire logic [3:0]  master_grant_n,
    input  wire logic        xfer_err_ack_n,
    input  wire logic        addr_retry_n,
    output logic [3:0]       master_request_n,
    output logic             xfer_start_n,
    output logic [4:0]       xfer_type,
    output logic [3:0]       xfer_size,
    output logic             xfer_burst_n,
    output logic             xfer_is_write,
    output logic [63:0]      proc_data_lines,
    output logic [7:0]       byte_parity_lines
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        master_request_n  = 4'hf;
        xfer_start_n      = 1'h1;
        xfer_type         = 5'h00;
        xfer_size         = 4'h0;
        xfer_burst_n      = 1'h1;
        xfer_is_write     = 1'h0;
        proc_data_lines   = 64'h0;
        byte_parity_lines = 8'h0;
    end

    // Odd sense inverts every lane
    function automatic logic [7:0] lane_parity(input logic [63:0] d, input logic odd);
        for (int i = 0; i < 8; i++) begin
            lane_parity[i] = ^d[8*i +: 8] ^ odd;
        end
    endfunction : lane_parity

    // Released data lines show the inverse, so a stale value is never mistaken for live data
    task automatic tenure(input int m, input logic [4:0] tt, input logic [3:0] sz, input logic bst_n,
                          input logic wr, input logic [63:0] d, input logic odd, input logic inj,
                          output logic ok);
        int n;
        ok = 1'h0;
        master_request_n[m] <= 1'h0;
        for (n = 0; n < 24 && !ok; n++) begin
            @(posedge aclk);
            ok = (master_grant_n[m] === 1'h0);
        end
        if (ok) begin
            xfer_start_n      <= 1'h0;
            xfer_type         <= tt;
            xfer_size         <= sz;
            xfer_burst_n      <= bst_n;
            xfer_is_write     <= wr;
            proc_data_lines   <= d;
            byte_parity_lines <= lane_parity(d, odd) ^ {7'h0, inj};
            @(posedge aclk);
            xfer_start_n        <= 1'h1;
            master_request_n[m] <= 1'h1;
            for (n = 0; n < 10; n++) begin
                @(posedge aclk);
                if (!xfer_err_ack_n || !addr_retry_n) break;
            end
        end
        master_request_n[m] <= 1'h1;
        proc_data_lines     <= ~proc_data_lines;
        byte_parity_lines   <= ~byte_parity_lines;
    endtask : tenure
endmodule : pba_bus_masters

//--- bench/processor_bus_slave_and_arbiter_test.sv
// Self-checking bench: termination, parity, status and arbitration
module processor_bus_slave_and_arbiter_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RETRY_WIN = 2;
    typedef struct {
        logic [2:0] gen;
        logic [3:0] sz;
        logic       bst_n, wr, nar, rty, apar, inj;
        int         acks, dvals, teas, arts, beats;
        logic [2:0] st;
    } pba_case_t;
    logic        aclk, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, slave_select = 1'h0, narrow_image = 1'h0;
    logic        retry_request = 1'h0, addr_parity_bad = 1'h0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_wstrb = 4'hf, s_axi_araddr = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [63:0] rd_buf_data = 64'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, xfer_start_n;
    logic        xfer_burst_n, xfer_is_write, xfer_ack_n, beat_valid_n, xfer_err_ack_n, addr_retry_n;
    logic        data_oe, rd_beat_taken, wr_fwd_valid, odd_sense, ok, dg_chk = 1'h0, dg_idle = 1'h0;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [3:0]  xfer_size, master_request_n, master_grant_n, data_grant_n, dg_exp, pm;
    logic [4:0]  xfer_type;
    logic [7:0]  byte_parity_lines, byte_parity_out;
    logic [31:0] s_axi_rdata, rd;
    logic [63:0] proc_data_lines, data_out, wr_fwd_data, wexp;
    int          errors, total_checks, cyc, t0, t_first, t_last, n_ack, n_dv, n_tea, n_art, n_both, n_rd, n_fwd;
    logic [3:0]  owners[$];
    // Control, size, burst_n, write, narrow, retry, bad address parity, bad data parity; then expectations
    pba_case_t   cases[12] = '{
        '{3'h0, 4'h4, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1, 0, 0, 0, 1, 3'h0},
        '{3'h2, 4'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1, 0, 0, 0, 1, 3'h0},
        '{3'h0, 4'h2, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 4, 0, 0, 0, 4, 3'h0},
        '{3'h0, 4'h9, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1, 2, 0, 0, 2, 3'h0},
        '{3'h0, 4'ha, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1, 3, 0, 0, 3, 3'h0},
        '{3'h0, 4'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 0, 0, 0, 1, 1, 3'h0},
        '{3'h4, 4'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 0, 0, 1, 0, 1, 3'h4},
        '{3'h0, 4'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1, 0, 0, 0, 1, 3'h4},
        '{3'h1, 4'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1, 0, 0, 0, 1, 3'h2},
        '{3'h0, 4'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1, 0, 0, 0, 1, 3'h0},
        '{3'h0, 4'h4, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1, 0, 0, 0, 1, 3'h1},
        '{3'h3, 4'h2, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 4, 0, 0, 0, 4, 3'h0}};

    pba_slave_arb #(.RETRY_WIN(RETRY_WIN)) pba_slave_arb_i (.*);
    pba_bus_masters pba_bus_masters_i (.*);

    initial begin
        aclk = 1'h0;
        forever #2.5 aclk = ~aclk;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    // No cycle limit here: only the watchdog ends a hung wait
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'h1;
        s_axi_wdata   <= d;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'h0;
        @(posedge aclk);
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        rd  = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'h0;
        @(posedge aclk);
    endtask : axi_rd

    // Counters restart at every start aimed at this slave
    always @(posedge aclk) begin
        cyc++;
        if (dg_idle) check(data_grant_n, 4'hf);
        dg_idle = dg_chk;
        if (dg_chk) check(data_grant_n, dg_exp);
        dg_chk = 1'h0;
        if (aresetn && xfer_start_n === 1'h0) begin
            dg_chk = 1'h1;
            dg_exp = xfer_type[3] ? master_grant_n : 4'hf;
            owners.push_back(master_grant_n);
            if (slave_select) begin
                t0 = cyc;
                {t_first, n_ack, n_dv, n_tea, n_art, n_both, n_rd, n_fwd} = '0;
            end
        end
        if (!xfer_ack_n || !beat_valid_n || !xfer_err_ack_n || !addr_retry_n) begin
            if (t_first == 0) t_first = cyc;
            t_last = cyc;
        end
        n_ack  += (xfer_ack_n === 1'h0);
        n_dv   += (beat_valid_n === 1'h0);
        n_tea  += (xfer_err_ack_n === 1'h0);
        n_art  += (addr_retry_n === 1'h0);
        n_both += (xfer_ack_n === 1'h0 && beat_valid_n === 1'h0);
        n_rd   += (rd_beat_taken === 1'h1);
        n_fwd  += (wr_fwd_valid === 1'h1);
        if (data_oe === 1'h1) begin
            check(data_out, rd_buf_data);
            check(byte_parity_out, pba_bus_masters_i.lane_parity(rd_buf_data, odd_sense));
        end
        if (wr_fwd_valid === 1'h1) check(wr_fwd_data, wexp);
    end

    task automatic run_case(input pba_case_t c, input int i);
        axi_wr(4'h0, {29'h0, c.gen});
        slave_select    <= 1'h1;
        narrow_image    <= c.nar;
        retry_request   <= c.rty;
        addr_parity_bad <= c.apar;
        rd_buf_data     <= 64'h0123456789abcdef ^ {16{4'(i)}};
        wexp      = 64'hfedcba9876543210 ^ {16{4'(i)}};
        odd_sense = c.gen[1];
        pba_bus_masters_i.tenure(0, 5'h08, c.sz, c.bst_n, c.wr, wexp, c.gen[1], c.inj, ok);
        repeat (8) @(posedge aclk);
        check(t_first - t0, RETRY_WIN + 1);
        check(t_last - t_first + 1, c.beats);
        check(n_ack, c.acks);
        check(n_dv, c.dvals);
        check(n_both, c.dvals > 0);
        check(n_tea, c.teas);
        check(n_art, c.arts);
        check(n_rd, (c.wr || c.teas || c.arts) ? 0 : c.beats);
        check(n_fwd, (!c.wr || c.teas || c.arts) ? 0 : c.beats);
        axi_rd(4'h8);
        check(rd[2:0], c.st);
        axi_wr(4'h8, 32'h7);
        $display("test %0d done", i);
    endtask : run_case

    task automatic arb3(input logic [31:0] ctrl, input logic [11:0] order);
        axi_wr(4'h4, ctrl);
        owners.delete();
        fork
            pba_bus_masters_i.tenure(1, 5'h08, 4'h0, 1'h1, 1'h0, 64'h0, 1'h0, 1'h0, ok);
            pba_bus_masters_i.tenure(2, 5'h08, 4'h0, 1'h1, 1'h0, 64'h0, 1'h0, 1'h0, ok);
            pba_bus_masters_i.tenure(3, 5'h08, 4'h0, 1'h1, 1'h0, 64'h0, 1'h0, 1'h0, ok);
        join
        for (int k = 0; k < 3; k++) check(owners[k], order[4*k +: 4]);
    endtask : arb3

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
        check(master_grant_n, 4'he);
        axi_rd(4'h0);
        check(rd, 32'h0);
        axi_rd(4'h4);
        check(rd, 32'h00f);
        axi_rd(4'hc);
        check({rsp, rd}, {2'h2, 32'h0});
        for (int i = 0; i < 12; i++) run_case(cases[i], i);
        slave_select <= 1'h0;
        arb3(32'h00f, 12'h7bd);
        arb3(32'h04f, 12'hdb7);
        axi_wr(4'h4, 32'h00b);
        pba_bus_masters_i.tenure(2, 5'h08, 4'h0, 1'h1, 1'h0, 64'h0, 1'h0, 1'h0, ok);
        check(ok, 1'h0);
        for (int p = 0; p < 4; p++) begin
            axi_wr(4'h4, 32'h10f | (p << 9));
            pba_bus_masters_i.tenure((p + 1) % 4, 5'h00, 4'h0, 1'h1, 1'h0, 64'h0, 1'h0, 1'h0, ok);
            repeat (3) @(posedge aclk);
            pm = ~(4'h1 << p);
            check(master_grant_n, pm);
        end
        axi_wr(4'h4, 32'h00f);
        pba_bus_masters_i.tenure(2, 5'h00, 4'h0, 1'h1, 1'h0, 64'h0, 1'h0, 1'h0, ok);
        repeat (3) @(posedge aclk);
        check(master_grant_n, 4'hb);
        $display("test arbiter done");
        summarize();
    end

    initial begin
        repeat (5000) @(posedge aclk);
        errors++;
        $display("wrong value at %0t: watchdog expired", $time);
        summarize();
    end
endmodule : processor_bus_slave_and_arbiter_test

//--- hdl/pba_cfg.svh
// Offsets, field positions, reset values and counts of the bus slave and arbiter
`ifndef PBA_CFG_SVH
`define PBA_CFG_SVH
`define PBA_OFF_GEN_CTRL   4'h0
`define PBA_OFF_ARB_CTRL   4'h4
`define PBA_OFF_STATUS     4'h8
`define PBA_GEN_DATA_PARITY_ENABLE      0
`define PBA_GEN_ODD        1
`define PBA_GEN_ERROR_ACK_ENABLE     2
`define PBA_GEN_RESET      3'h0
`define PBA_ARB_EN_LSB     0
`define PBA_ARB_PRI_LSB    4
`define PBA_ARB_PARK_FIXED 8
`define PBA_ARB_PARK_LSB   9
`define PBA_ARB_RESET      11'h00f
`define PBA_ERR_ADDR_PAR   0
`define PBA_ERR_DATA_PAR   1
`define PBA_ERR_ILLEGAL    2
`define PBA_RETRY_WIN      2
`define PBA_BEATS_BURST    3'h4
`define PBA_RESP_OKAY      2'h0
`define PBA_RESP_SLVERR    2'h2
`endif

//--- hdl/pba_pkg.sv
// Types shared by the processor bus slave and arbiter
package pba_pkg;
    typedef enum logic [1:0] {
        PBA_IDLE,
        PBA_WAIT,
        PBA_BEATS
    } pba_tstate_t;
endpackage : pba_pkg

//--- hdl/pba_slave_arb.sv
// Processor bus slave termination, data parity and four-master arbiter with AXI4-Lite registers
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`include "pba_cfg.svh"

module pba_slave_arb #(
    parameter int RETRY_WIN = `PBA_RETRY_WIN
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        xfer_start_n,
    input  wire logic [4:0]  xfer_type,
    input  wire logic [3:0]  xfer_size,
    input  wire logic        xfer_burst_n,
    input  wire logic        slave_select,
    input  wire logic        xfer_is_write,
    input  wire logic        narrow_image,
    input  wire logic        retry_request,
    input  wire logic        addr_parity_bad,
    input  wire logic [63:0] proc_data_lines,
    input  wire logic [7:0]  byte_parity_lines,
    input  wire logic [63:0] rd_buf_data,
    input  wire logic [3:0]  master_request_n,
    output logic [3:0]       master_grant_n,
    output logic [3:0]       data_grant_n,
    output logic             xfer_ack_n,
    output logic             beat_valid_n,
    output logic             xfer_err_ack_n,
    output logic             addr_retry_n,
    output logic [63:0]      data_out,
    output logic             data_oe,
    output logic [7:0]       byte_parity_out,
    output logic             rd_beat_taken,
    output logic [63:0]      wr_fwd_data,
    output logic             wr_fwd_valid
);
    // Window must hold at least two idle cycles and fit the 3-bit counter
    if (RETRY_WIN < 2 || RETRY_WIN > 7) begin : g_bad_win
        $error("RETRY_WIN out of range");
    end

    typedef struct packed {
        logic                 awready;
        logic                 wready;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 arready;
        logic                 rvalid;
        logic [1:0]           rresp;
        logic [31:0]          rdata;
        logic                 aw_full;
        logic [3:0]           aw_addr;
        logic                 w_full;
        logic [31:0]          w_data;
        logic [3:0]           w_strb;
        logic [2:0]           gen_ctrl;
        logic [10:0]          arb_ctrl;
        logic [2:0]           err;
        pba_pkg::pba_tstate_t tstate;
        logic [2:0]           cnt;
        logic [2:0]           beats_left;
        logic                 is_write;
        logic                 is_ext;
        logic                 is_bad;
        logic                 retry;
        logic                 ta_n;
        logic                 dval_n;
        logic                 tea_n;
        logic                 artry_n;
        logic [63:0]          dout;
        logic                 doe;
        logic [7:0]           pout;
        logic                 rd_taken;
        logic [63:0]          wdat;
        logic                 wval;
        logic [1:0]           owner;
        logic [3:0]           gnt_n;
        logic [3:0]           dgnt_n;
    } pba_state_t;

    pba_state_t s;
    pba_state_t next_s;

    function automatic logic [7:0] lane_parity(input logic [63:0] d, input logic odd);
        logic [7:0] p;
        p = '0;
        for (int i = 0; i < 8; i++) begin
            p[i] = (^d[8*i +: 8]) ^ odd;
        end
        return p;
    endfunction : lane_parity

    // Round robin: first candidate after the current owner
    function automatic logic [1:0] rr_pick(input logic [3:0] cand, input logic [1:0] from);
        logic [1:0] idx;
        logic [1:0] pick;
        logic       found;
        pick  = from;
        found = 1'b0;
        for (int i = 1; i <= 4; i++) begin
            idx = from + i[1:0];
            if (!found && cand[idx]) begin
                pick  = idx;
                found = 1'b1;
            end
        end
        return pick;
    endfunction : rr_pick

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    logic [3:0] elig;
    logic [3:0] hi;
    logic [3:0] cand;
    logic       ts;
    logic [2:0] beats;
    logic       ext;
    logic       wide;
    logic       wbeat;
    logic       ar_hit;
    logic       go_beat;
    logic [31:0] mrg;

    always_comb begin
        next_s = s;
        next_s.bresp = s.bresp;
        ts    = !xfer_start_n;
        ext   = xfer_burst_n && xfer_size[3];
        beats = !xfer_burst_n ? `PBA_BEATS_BURST : (ext ? (xfer_size[2:0] == 3'h1 ? 3'h2 : 3'h3) : 3'h1);
        wide  = !xfer_burst_n || xfer_size[3] || xfer_size[2:0] == 3'h0 || xfer_size[2:0] > 3'h4;
        elig  = ~master_request_n & s.arb_ctrl[`PBA_ARB_EN_LSB +: 4];
        hi    = elig & s.arb_ctrl[`PBA_ARB_PRI_LSB +: 4];
        cand  = (|hi) ? hi : elig;
        wbeat = s.is_write && (!s.ta_n || !s.dval_n) && s.artry_n;
        ar_hit = 1'b0;
        go_beat = 1'b0;
        mrg    = '0;

        // AXI4-Lite write: address and data accepted in either order
        if (s_axi_awvalid && s.awready) begin
            next_s.aw_full = 1'b1;
            next_s.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready) begin
            next_s.w_full = 1'b1;
            next_s.w_data = s_axi_wdata;
            next_s.w_strb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end
        if (s.aw_full && s.w_full && !s.bvalid) begin
            next_s.aw_full = 1'b0;
            next_s.w_full  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = `PBA_RESP_OKAY;
            case (s.aw_addr)
                `PBA_OFF_GEN_CTRL: begin
                    mrg             = merge({29'h0, s.gen_ctrl}, s.w_data, s.w_strb);
                    next_s.gen_ctrl = mrg[2:0];
                end
                `PBA_OFF_ARB_CTRL: begin
                    mrg             = merge({21'h0, s.arb_ctrl}, s.w_data, s.w_strb);
                    next_s.arb_ctrl = mrg[10:0];
                end
                `PBA_OFF_STATUS:   next_s.err = s.err & ~(s.w_data[2:0] & {3{s.w_strb[0]}});
                default:           next_s.bresp = `PBA_RESP_SLVERR;
            endcase
        end
        next_s.awready = !next_s.aw_full && !next_s.bvalid;
        next_s.wready  = !next_s.w_full && !next_s.bvalid;

        // AXI4-Lite read
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s.arready) begin
            ar_hit        = 1'b1;
            next_s.rvalid = 1'b1;
            next_s.rresp  = `PBA_RESP_OKAY;
            case (s_axi_araddr)
                `PBA_OFF_GEN_CTRL: next_s.rdata = {29'h0, s.gen_ctrl};
                `PBA_OFF_ARB_CTRL: next_s.rdata = {21'h0, s.arb_ctrl};
                `PBA_OFF_STATUS:   next_s.rdata = {26'h0, s.owner, 1'b0, s.err};
                default: begin
                    next_s.rdata = 32'h0;
                    next_s.rresp = `PBA_RESP_SLVERR;
                end
            endcase
        end
        next_s.arready = !next_s.rvalid && !ar_hit;

        // Terminations and data are one-cycle pulses unless reissued
        next_s.ta_n     = 1'b1;
        next_s.dval_n   = 1'b1;
        next_s.tea_n    = 1'b1;
        next_s.artry_n  = 1'b1;
        next_s.doe      = 1'b0;
        next_s.rd_taken = 1'b0;
        next_s.wval     = 1'b0;

        // Write capture is independent of the read buffer and of parity outcome
        if (wbeat) begin
            next_s.wdat = proc_data_lines;
            next_s.wval = 1'b1;
            if (s.gen_ctrl[`PBA_GEN_DATA_PARITY_ENABLE] &&
                byte_parity_lines != lane_parity(proc_data_lines, s.gen_ctrl[`PBA_GEN_ODD])) begin
                next_s.err[`PBA_ERR_DATA_PAR] = 1'b1;
            end
        end

        case (s.tstate)
            pba_pkg::PBA_IDLE: begin
                if (ts && slave_select) begin
                    next_s.tstate   = pba_pkg::PBA_WAIT;
                    next_s.cnt      = 3'(RETRY_WIN - 1);
                    next_s.is_write = xfer_is_write;
                    next_s.is_ext   = ext;
                    next_s.is_bad   = narrow_image && wide;
                    next_s.retry    = retry_request;
                    next_s.beats_left = beats;
                    if (addr_parity_bad) begin
                        next_s.err[`PBA_ERR_ADDR_PAR] = 1'b1;
                    end
                    if (narrow_image && wide) begin
                        next_s.err[`PBA_ERR_ILLEGAL] = 1'b1;
                    end
                end
            end
            pba_pkg::PBA_WAIT: begin
                // Hold every termination until the retry window is over
                next_s.cnt = s.cnt - 3'h1;
                if (s.cnt == 3'h0) begin
                    if (s.retry) begin
                        next_s.artry_n = 1'b0;
                        next_s.tstate  = pba_pkg::PBA_IDLE;
                    end else if (s.is_bad && s.gen_ctrl[`PBA_GEN_ERROR_ACK_ENABLE]) begin
                        next_s.tea_n  = 1'b0;
                        next_s.tstate = pba_pkg::PBA_IDLE;
                    end else begin
                        // First beat shares the cycle a retry would have used
                        next_s.tstate = pba_pkg::PBA_BEATS;
                        go_beat       = 1'b1;
                    end
                end
            end
            pba_pkg::PBA_BEATS: begin
                go_beat = 1'b1;
            end
            default: next_s.tstate = pba_pkg::PBA_IDLE;
        endcase

        if (go_beat) begin
                // Beats run back to back; the back end must keep pace
                next_s.beats_left = s.beats_left - 3'h1;
                if (s.is_ext) begin
                    next_s.dval_n = 1'b0;
                    next_s.ta_n   = (s.beats_left != 3'h1);
                end else begin
                    next_s.ta_n = 1'b0;
                end
                if (!s.is_write) begin
                    next_s.dout     = rd_buf_data;
                    next_s.pout     = lane_parity(rd_buf_data, s.gen_ctrl[`PBA_GEN_ODD]);
                    next_s.doe      = 1'b1;
                    next_s.rd_taken = 1'b1;
                end
                if (s.beats_left == 3'h1) begin
                    next_s.tstate = pba_pkg::PBA_IDLE;
                end
        end

        // Data grant: one cycle after start, taken as qualified at that edge
        next_s.dgnt_n = 4'hf;
        if (ts && xfer_type[3]) begin
            next_s.dgnt_n = ~(4'h1 << s.owner);
        end

        // Address bus grant; busy lines are not watched
        if (ts || !elig[s.owner]) begin
            if (|cand) begin
                next_s.owner = rr_pick(cand, s.owner);
            end else if (s.arb_ctrl[`PBA_ARB_PARK_FIXED]) begin
                next_s.owner = s.arb_ctrl[`PBA_ARB_PARK_LSB +: 2];
            end
        end
        next_s.gnt_n = ~((4'h1 << next_s.owner) & next_s.arb_ctrl[`PBA_ARB_EN_LSB +: 4]);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s          <= '0;
            s.gen_ctrl <= `PBA_GEN_RESET;
            s.arb_ctrl <= `PBA_ARB_RESET;
            s.tstate   <= pba_pkg::PBA_IDLE;
            s.ta_n     <= 1'b1;
            s.dval_n   <= 1'b1;
            s.tea_n    <= 1'b1;
            s.artry_n  <= 1'b1;
            s.gnt_n    <= 4'hf;
            s.dgnt_n   <= 4'hf;
        end else begin
            s <= next_s;
        end
    end

    assign s_axi_awready   = s.awready;
    assign s_axi_wready    = s.wready;
    assign s_axi_bvalid    = s.bvalid;
    assign s_axi_bresp     = s.bresp;
    assign s_axi_arready   = s.arready;
    assign s_axi_rvalid    = s.rvalid;
    assign s_axi_rresp     = s.rresp;
    assign s_axi_rdata     = s.rdata;
    assign master_grant_n  = s.gnt_n;
    assign data_grant_n    = s.dgnt_n;
    assign xfer_ack_n      = s.ta_n;
    assign beat_valid_n    = s.dval_n;
    assign xfer_err_ack_n  = s.tea_n;
    assign addr_retry_n    = s.artry_n;
    assign data_out        = s.dout;
    assign data_oe         = s.doe;
    assign byte_parity_out = s.pout;
    assign rd_beat_taken   = s.rd_taken;
    assign wr_fwd_data     = s.wdat;
    assign wr_fwd_valid    = s.wval;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence seq_start;
        !xfer_start_n && slave_select && s.tstate == pba_pkg::PBA_IDLE;
    endsequence
    sequence seq_quiet;
        xfer_ack_n && beat_valid_n && xfer_err_ack_n;
    endsequence

    AST_NO_EARLY_TERM: assert property (seq_start |=> seq_quiet ##1 seq_quiet)
        else $error("termination inside retry window");
    AST_DGNT_NEXT: assert property (!xfer_start_n && xfer_type[3] |=> data_grant_n == ~(4'h1 << $past(s.owner)))
        else $error("data grant missing after start");
    AST_ADDR_ONLY: assert property (!xfer_start_n && !xfer_type[3] |=> &data_grant_n)
        else $error("data grant on address-only cycle");
    AST_DGNT_DROP: assert property (!(&data_grant_n) |=> &data_grant_n)
        else $error("data grant held too long");
    AST_RETRY_NO_ACK: assert property (!addr_retry_n |-> xfer_ack_n && beat_valid_n)
        else $error("acknowledge with retry");
    AST_NO_GAP: assert property (!beat_valid_n && xfer_ack_n |=> !beat_valid_n)
        else $error("gap in extended beats");
    AST_TEA_GATED: assert property (!xfer_err_ack_n |-> $past(s.gen_ctrl[`PBA_GEN_ERROR_ACK_ENABLE]))
        else $error("error acknowledge while disabled");
    AST_RD_PARITY: assert property (data_oe |-> byte_parity_out == lane_parity(data_out, $past(s.gen_ctrl[1])))
        else $error("read parity wrong");
    AST_WR_FWD: assert property (s.is_write && !xfer_ack_n && addr_retry_n |=> wr_fwd_valid)
        else $error("write beat not forwarded");
    AST_ONE_GRANT: assert property ($onehot0(~master_grant_n))
        else $error("two address grants");
endmodule : pba_slave_arb
